// >>> dv/scp_link_properties.sv
// concurrent checks on the serial control link between host and device ends
`timescale 1ns/1ps
`default_nettype none
module scp_link_properties (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// link
	input wire logic mode_pin,
	input wire logic sclk,
	input wire logic sel_pin,
	input wire logic host_din_o,
	input wire logic host_din_oe_n,
	input wire logic dev_din_o,
	input wire logic dev_din_oe_n,
	input wire logic dev_dout_oe_n,
	input wire logic din_line
);
	logic [4:0] cnt_ff;
	logic       rw_ff;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// ****
	// frame tracking
	// ****
	// count restarts at the select fall, so a late release after the frame still sees the full count
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= 5'h00;
			rw_ff  <= 1'b0;
		end else if ($fell(sel_pin)) begin
			cnt_ff <= 5'h00;
		end else if ($rose(sclk)) begin
			cnt_ff <= cnt_ff + 5'h01;
			if (cnt_ff == 5'h00) begin
				rw_ff <= din_line;
			end
		end
	end

	sequence high_half;
		sclk [*8];
	endsequence
	sequence low_half;
		!sclk [*8];
	endsequence

	// ****
	// properties
	// ****
	sclk_idle_a: assert property (sel_pin |-> !sclk)
		else $error("serial clock moved outside a frame");
	high_half_a: assert property ($rose(sclk) |-> high_half ##1 !sclk)
		else $error("serial clock high half not 8 cycles");
	low_half_a: assert property ($fell(sclk) |-> low_half)
		else $error("serial clock low half too short");
	word_length_a: assert property ($rose(sel_pin) |-> cnt_ff == 5'h18 || cnt_ff == 5'h00)
		else $error("frame did not carry 24 bits");
	no_contention_a: assert property (!(!host_din_oe_n && !dev_din_oe_n))
		else $error("host and device drive data line together");
	read_drive_a: assert property (!dev_din_oe_n |-> rw_ff && cnt_ff >= 5'h08)
		else $error("device drove data line outside read data");
	single_output_a: assert property (!(!dev_din_oe_n && !dev_dout_oe_n))
		else $error("device drives both data outputs");
	hw_released_a: assert property (!mode_pin [*8] |-> dev_din_oe_n && dev_dout_oe_n)
		else $error("device drives link in hardware mode");
	data_hold_a: assert property (sclk && $past(sclk) && !dev_din_oe_n |-> $stable(dev_din_o))
		else $error("readback bit changed while clock high");
	host_hold_a: assert property (sclk && $past(sclk) && !host_din_oe_n |-> $stable(host_din_o))
		else $error("host bit changed while clock high");
endmodule : scp_link_properties
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench: host and device ends joined over the serial control link
`timescale 1ns/1ps
`default_nettype none
`include "scp_cfg.svh"
module testbench;
	logic        clock;
	logic        sys_rst;
	logic [3:0]  sw_addr;
	logic [15:0] sw_wdata;
	logic        sw_wr;
	logic        sw_rd;
	logic [15:0] sw_rdata;
	logic        host_irq;
	logic        bit_clock_present;
	logic        right_channel;
	logic        device_enable;
	logic        quad_rate_variant;
	logic        use_bit_clock;
	logic        dev_irq;
	logic        alert_poll_request;
	logic        irq_on;
	logic [15:0] q;
	int          mismatches;
	int          samples_checked;

	scp_link_if lnk ();
	scp_host scp_host_inst (.clock(clock), .sys_rst(sys_rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(host_irq), .link(lnk));
	scp_device scp_device_inst (.clock(clock), .sys_rst(sys_rst), .link(lnk), .bit_clock_present(bit_clock_present),
		.right_channel(right_channel), .device_enable(device_enable), .quad_rate_variant(quad_rate_variant),
		.use_bit_clock(use_bit_clock), .irq(dev_irq), .alert_poll_request(alert_poll_request));
	scp_link_properties scp_link_properties_inst (.clock(clock), .sys_rst(sys_rst), .mode_pin(lnk.mode_pin),
		.sclk(lnk.sclk), .sel_pin(lnk.sel_pin), .host_din_o(lnk.host_din_o), .host_din_oe_n(lnk.host_din_oe_n),
		.dev_din_o(lnk.dev_din_o), .dev_din_oe_n(lnk.dev_din_oe_n), .dev_dout_oe_n(lnk.dev_dout_oe_n),
		.din_line(lnk.din_line));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ****
	// access tasks
	// ****
	task automatic end_of_test;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		sw_addr  <= a;
		sw_wdata <= d;
		sw_wr    <= 1'b1;
		@(posedge clock);
		sw_wr <= 1'b0;
	endtask : wr

	// read data is sampled mid-cycle, clear of the edge that loads it
	task automatic rd(input logic [3:0] a, output logic [15:0] r);
		@(posedge clock);
		sw_addr <= a;
		sw_rd   <= 1'b1;
		@(posedge clock);
		sw_rd <= 1'b0;
		@(negedge clock);
		r = sw_rdata;
	endtask : rd

	task automatic xfer(input logic rw, input logic [6:0] a, input logic [15:0] d, output logic [15:0] r);
		int          n;
		logic [15:0] s;
		wr(`H_TXD, d);
		wr(`H_CMD, {8'h00, rw, a});
		rd(`H_STAT, s);
		chk("host busy", 16'h0001, 16'(s[1]));
		n = 0;
		s = 16'h0000;
		while (s[0] !== 1'b1) begin
			rd(`H_STAT, s);
			n++;
			if (n > 1000) begin
				mismatches++;
				end_of_test();
			end
		end
		chk("host irq", 16'(irq_on), 16'(host_irq));
		wr(`H_STAT, 16'h0001);
		rd(`H_STAT, s);
		chk("host done clear", 16'h0000, 16'(s[0]));
		chk("host irq clear", 16'h0000, 16'(host_irq));
		rd(`H_RXD, r);
	endtask : xfer

	task automatic dwr(input logic [6:0] a, input logic [15:0] d);
		xfer(1'b0, a, d, q);
	endtask : dwr

	task automatic drd(input logic [6:0] a, input logic [15:0] e);
		xfer(1'b1, a, 16'h0000, q);
		chk("device read", e, q);
	endtask : drd

	// ****
	// main sequence
	// ****
	initial begin
		sys_rst           = 1'b1;
		sw_addr           = 4'h0;
		sw_wdata          = 16'h0000;
		sw_wr             = 1'b0;
		sw_rd             = 1'b0;
		bit_clock_present = 1'b0;
		irq_on            = 1'b1;
		mismatches        = 0;
		samples_checked   = 0;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		wr(`H_MASK, 16'h0001);
		for (int i = 0; i < 16; i++) begin
			wr(`H_CTRL, {11'h000, i[2], i[1], 1'b0, i[0], 1'b0});
			bit_clock_present <= i[3];
			repeat (10) @(negedge clock);
			chk("right channel", 16'(i[0]), 16'(right_channel));
			chk("quad rate", 16'(i[1]), 16'(quad_rate_variant));
			chk("bit clock source", 16'(i[1]), 16'(use_bit_clock));
			chk("enable", 16'(i[1] ? i[3] : i[2]), 16'(device_enable));
		end
		wr(`H_CTRL, 16'h000b);
		repeat (10) @(negedge clock);
		chk("software enable", 16'h0001, 16'(device_enable));
		drd(`CFG_REG_ADDR, `CFG_RESET);
		dwr(`MASK_REG_ADDR, 16'h0001);
		dwr(7'h10, 16'ha5c3);
		drd(7'h10, 16'ha5c3);
		chk("device irq held", 16'h0001, 16'(dev_irq));
		chk("alert off", 16'h0000, 16'(alert_poll_request));
		dwr(`CFG_REG_ADDR, 16'h000a);
		chk("alert on", 16'h0001, 16'(alert_poll_request));
		dwr(`STAT_REG_ADDR, 16'h0003);
		chk("device irq clear", 16'h0000, 16'(dev_irq));
		drd(`STAT_REG_ADDR, 16'h0002);
		dwr(`CFG_REG_ADDR, 16'h0012);
		wr(`H_CTRL, 16'h000f);
		repeat (4) @(negedge clock);
		chk("output idle low", 16'h0000, 16'(lnk.dout_line));
		drd(7'h10, 16'ha5c3);
		dwr(`CFG_REG_ADDR, 16'h0032);
		chk("output released", 16'h0001, 16'(lnk.dout_line));
		drd(7'h10, 16'ha5c3);
		wr(`H_MASK, 16'h0000);
		irq_on = 1'b0;
		dwr(7'h11, 16'h5a3c);
		drd(7'h11, 16'h5a3c);
		rd(4'hf, q);
		chk("unmapped", 16'h0000, q);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire

// >>> hdl/scp_cfg.svh
// constants for the serial control port link: offsets, fields, resets and timing
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH

// ****************************************
// device register map
// ****************************************
`define REG_WORDS      128
`define CFG_REG_ADDR   7'h28
`define STAT_REG_ADDR  7'h29
`define MASK_REG_ADDR  7'h2a
`define CFG_RESET      16'h0002
`define AUTO_INC_BIT   1
`define ALERT_POLL_BIT 3
`define FOUR_LINE_BIT  4
`define OPEN_DRAIN_BIT 5
`define EV_WRITE       0
`define EV_READ        1

// ****************************************
// control word layout
// ****************************************
`define HDR_BITS       4'h8
`define DATA_BITS      5'h10
`define WORD_BITS      5'h18

// ****************************************
// host register map and control fields
// ****************************************
`define H_CTRL         4'h0
`define H_CMD          4'h1
`define H_TXD          4'h2
`define H_RXD          4'h3
`define H_STAT         4'h4
`define H_MASK         4'h5
`define HC_CONTROL_MODE_SELECT_PIN      0
`define HC_CHAN        1
`define HC_FOUR        2
`define HC_SEL         3
`define HC_ENA         4

// ****************************************
// timing
// ****************************************
`define CLOCK_NS       10
`define LINK_HALF_NS   80
`define LINK_HALF_CYC  ((`LINK_HALF_NS + `CLOCK_NS - 1) / `CLOCK_NS)

`endif

// >>> hdl/scp_device.sv
// control port device end: 3/4-wire register access and hardware pin decoding
//
// Behaviour
// - auto-increment bit 1 steps addresses, resets on
// - alert poll only while bit 3 set
// - alert held until host clears status
// - word: rw, seven address, sixteen data
// - one bit per rising serial clock
// - select rising latches last 24 bits
// - host drives every bit on writes
// - 3-wire read: device drives data bits
// - 4-wire read ignores input, uses output
// - idle output: low push-pull, released open-drain
// - mode pin low selects hardware mode
// - channel pin: 0 left, 1 right
// - normal mode: enable follows enable pin
// - select pin 0: normal, master clock
// - select pin 1: quad rate, bit clock
// - bit 4 chooses 3-wire or 4-wire
// - bit 5 chooses push-pull or open-drain
// - mode pin high selects software mode; here the serial port also needs the channel pin high
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "scp_cfg.svh"
module scp_device
	import scp_pkg::*;
(
	// clock and reset
	input  wire logic clock,
	input  wire logic sys_rst,
	// link
	scp_link_if.device link,
	// audio side controls
	input  wire logic bit_clock_present,
	output logic      right_channel,
	output logic      device_enable,
	output logic      quad_rate_variant,
	output logic      use_bit_clock,
	// alert
	output logic      irq,
	output logic      alert_poll_request
);
	dev_state_t s;
	dev_state_t n;

	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic soft3;
	logic four;
	logic inc;
	logic bit_in;

	function automatic logic filt(input logic [2:0] c, input logic prev);
		return (c[1] == c[2]) ? c[2] : prev;
	endfunction : filt

	function automatic logic [15:0] rd_word(input dev_state_t st, input logic [6:0] a);
		case (a)
			`CFG_REG_ADDR:  return st.cfg;
			`STAT_REG_ADDR: return {14'h0000, st.stat};
			`MASK_REG_ADDR: return {14'h0000, st.mask};
			default:        return st.regs[a];
		endcase
	endfunction : rd_word

	function automatic dev_state_t wr_word(input dev_state_t st, input logic [6:0] a, input logic [15:0] d);
		dev_state_t r;
		r = st;
		case (a)
			`CFG_REG_ADDR:  r.cfg = d;
			// status clears only by writing ones; interrupt is never dropped by a poll
			`STAT_REG_ADDR: r.stat = st.stat & ~d[1:0];
			`MASK_REG_ADDR: r.mask = d[1:0];
			default:        r.regs[a] = d;
		endcase
		if (a != `STAT_REG_ADDR)
			r.stat[`EV_WRITE] = 1'b1;
		return r;
	endfunction : wr_word

	always_comb begin
		n = s;
		// ****************************************
		// pin synchronisers
		// ****************************************
		n.sclk_s = {s.sclk_s[1:0], link.sclk};
		n.cs_s   = {s.cs_s[1:0], link.sel_pin};
		n.din_s  = {s.din_s[1:0], link.din_line};
		n.mode_s = {s.mode_s[1:0], link.mode_pin};
		n.chan_s = {s.chan_s[1:0], link.chan_pin};
		n.sclk_l = filt(s.sclk_s, s.sclk_l);
		n.cs_l   = filt(s.cs_s, s.cs_l);
		n.din_l  = filt(s.din_s, s.din_l);
		n.mode_l = filt(s.mode_s, s.mode_l);
		n.chan_l = filt(s.chan_s, s.chan_l);
		sclk_rise = !s.sclk_l && n.sclk_l;
		sclk_fall = s.sclk_l && !n.sclk_l;
		cs_rise   = !s.cs_l && n.cs_l;
		soft3     = s.mode_l && s.chan_l;
		four      = s.cfg[`FOUR_LINE_BIT];
		inc       = s.cfg[`AUTO_INC_BIT];
		// data pin is ignored once the read address is in
		bit_in    = (s.rw && s.hcnt == `HDR_BITS) ? 1'b0 : s.din_l;
		// ****************************************
		// serial word reception
		// ****************************************
		if (soft3 && !s.cs_l && sclk_rise) begin
			n.shift = {s.shift[22:0], bit_in};
			if (s.hcnt != `HDR_BITS) begin
				n.hcnt = s.hcnt + 4'h1;
				if (s.hcnt == `HDR_BITS - 4'h1) begin
					n.rw    = s.shift[6];
					n.addr  = {s.shift[5:0], bit_in};
					n.dcnt  = 5'h00;
					n.ocnt  = 5'h00;
					n.tx_on = s.shift[6];
					if (s.shift[6])
						n.stat[`EV_READ] = 1'b1;
				end
			end else if (s.dcnt == `DATA_BITS) begin
				// a further bit opens the next word of a block
				n.dcnt = 5'h01;
				if (inc) begin
					n.blk = 1'b1;
					if (!s.rw) begin
						n = wr_word(n, s.addr, s.shift[15:0]);
						n.addr = s.addr + 7'h01;
					end
				end
			end else begin
				n.dcnt = s.dcnt + 5'h01;
			end
		end
		// ****************************************
		// readback shifting
		// ****************************************
		if (soft3 && !s.cs_l && sclk_fall && s.tx_on) begin
			if (s.ocnt == 5'h00 || (s.ocnt == `DATA_BITS && inc)) begin
				if (s.ocnt != 5'h00)
					n.addr = s.addr + 7'h01;
				n.tx   = rd_word(s, n.addr);
				n.dout = n.tx[15];
				n.tx   = {n.tx[14:0], 1'b0};
				n.ocnt = 5'h01;
			end else if (s.ocnt < `DATA_BITS) begin
				n.dout = s.tx[15];
				n.tx   = {s.tx[14:0], 1'b0};
				n.ocnt = s.ocnt + 5'h01;
			end else begin
				n.tx_on = 1'b0;
				n.dout  = 1'b0;
			end
		end
		// ****************************************
		// end of frame
		// ****************************************
		if (cs_rise && soft3) begin
			if (s.hcnt == `HDR_BITS && s.dcnt == `DATA_BITS && !s.rw) begin
				if (s.blk)
					n = wr_word(n, s.addr, s.shift[15:0]);
				else if (!s.shift[23])
					n = wr_word(n, s.shift[22:16], s.shift[15:0]);
			end
		end
		if (n.cs_l || !soft3) begin
			n.hcnt  = 4'h0;
			n.dcnt  = 5'h00;
			n.blk   = 1'b0;
			n.rw    = 1'b0;
			n.tx_on = 1'b0;
			n.dout  = 1'b0;
		end
		// ****************************************
		// pin drivers
		// ****************************************
		n.din_oe_n = !(soft3 && !four && n.tx_on && n.ocnt != 5'h00);
		n.dout_o   = 1'b0;
		n.dout_oe_n = 1'b1;
		if (soft3 && four) begin
			if (n.tx_on && n.ocnt != 5'h00) begin
				// open drain lets the pull-up carry a one
				n.dout_o    = n.dout;
				n.dout_oe_n = s.cfg[`OPEN_DRAIN_BIT] ? n.dout : 1'b0;
			end else begin
				n.dout_oe_n = s.cfg[`OPEN_DRAIN_BIT];
			end
		end
		// ****************************************
		// hardware mode decoding
		// ****************************************
		if (!s.mode_l) begin
			n.right  = s.chan_l;
			n.quad   = s.cs_l;
			// quad rate powers itself from the bit clock, enable pin unused
			n.enable = s.cs_l ? bit_clock_present : s.din_l;
		end else begin
			n.right  = 1'b0;
			n.quad   = 1'b0;
			n.enable = 1'b1;
		end
		n.irq   = |(n.stat & n.mask);
		n.alert = n.irq && s.cfg[`ALERT_POLL_BIT];
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			s <= '{cs_s: 3'b111, cs_l: 1'b1, cfg: `CFG_RESET, din_oe_n: 1'b1, dout_oe_n: 1'b1, default: '0};
		else
			s <= n;
	end

	assign link.dev_din_o     = s.dout;
	assign link.dev_din_oe_n  = s.din_oe_n;
	assign link.dev_dout_o    = s.dout_o;
	assign link.dev_dout_oe_n = s.dout_oe_n;
	assign right_channel      = s.right;
	assign device_enable      = s.enable;
	assign quad_rate_variant  = s.quad;
	assign use_bit_clock      = s.quad;
	assign irq                = s.irq;
	assign alert_poll_request = s.alert;
endmodule : scp_device
`default_nettype wire

// >>> hdl/scp_host.sv
// serial bus controller end: sends 24-bit control words and collects readback
`timescale 1ns/1ps
`default_nettype none
`include "scp_cfg.svh"
module scp_host
	import scp_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// software register port
	input  wire logic [3:0]  sw_addr,
	input  wire logic [15:0] sw_wdata,
	input  wire logic        sw_wr,
	input  wire logic        sw_rd,
	output logic      [15:0] sw_rdata,
	output logic             irq,
	// link
	scp_link_if.host         link
);
	localparam logic [7:0] HALF = 8'(`LINK_HALF_CYC);

	host_state_t s;
	host_state_t n;

	function automatic logic filt(input logic [2:0] c, input logic prev);
		return (c[1] == c[2]) ? c[2] : prev;
	endfunction : filt

	always_comb begin
		n = s;
		n.din_s  = {s.din_s[1:0], link.din_line};
		n.dout_s = {s.dout_s[1:0], link.dout_line};
		n.din_l  = filt(s.din_s, s.din_l);
		n.dout_l = filt(s.dout_s, s.dout_l);
		n.rdata  = 16'h0000;
		n.div    = s.div + 8'h01;
		// ****************************************
		// link sequencing
		// ****************************************
		case (s.phase)
			H_IDLE: begin
				n.sclk     = 1'b0;
				n.cs       = s.ctrl[`HC_SEL];
				n.din_o    = s.ctrl[`HC_ENA];
				n.din_oe_n = 1'b0;
			end
			H_LOW: begin
				n.sclk = 1'b0;
				n.din_o = s.shift[23];
				n.din_oe_n = s.rd && (s.cnt >= 5'(`HDR_BITS));
				if (s.div == HALF - 8'h01) begin
					n.div   = 8'h00;
					n.phase = H_HIGH;
				end
			end
			H_HIGH: begin
				n.sclk = 1'b1;
				if (s.div == HALF - 8'h01) begin
					n.div   = 8'h00;
					n.shift = {s.shift[22:0], 1'b0};
					n.cnt   = s.cnt + 5'h01;
					if (s.cnt >= 5'(`HDR_BITS))
						n.rx = {s.rx[14:0], s.ctrl[`HC_FOUR] ? s.dout_l : s.din_l};
					n.phase = (s.cnt == `WORD_BITS - 5'h01) ? H_END : H_LOW;
				end
			end
			H_END: begin
				n.sclk = 1'b0;
				if (s.div == HALF - 8'h01) begin
					n.div = 8'h00;
					// data line stays released a further half period: the device lets go only after its select sync
					if (!s.cs) begin
						n.cs = 1'b1;
					end else begin
						n.phase = H_IDLE;
						n.done  = 1'b1;
						if (s.rd)
							n.rxd = s.rx;
					end
				end
			end
			default: n.phase = H_IDLE;
		endcase
		// ****************************************
		// software port
		// ****************************************
		if (sw_wr) begin
			case (sw_addr)
				`H_CTRL: n.ctrl = sw_wdata[4:0];
				`H_TXD:  n.txd = sw_wdata;
				`H_MASK: n.mask = sw_wdata[0];
				`H_STAT: n.done = n.done
					& ~(sw_wdata[0] & ~(s.phase == H_END && s.cs && s.div == HALF - 8'h01));
				`H_CMD: begin
					// a command while busy is dropped
					if (s.phase == H_IDLE) begin
						n.shift = {sw_wdata[7:0], s.txd};
						n.rd    = sw_wdata[7];
						n.cnt   = 5'h00;
						n.div   = 8'h00;
						n.cs    = 1'b0;
						n.phase = H_LOW;
					end
				end
				default: n.ctrl = s.ctrl;
			endcase
		end
		if (sw_rd) begin
			case (sw_addr)
				`H_CTRL: n.rdata = {11'h000, s.ctrl};
				`H_CMD:  n.rdata = {8'h00, s.rd, 7'h00};
				`H_TXD:  n.rdata = s.txd;
				`H_RXD:  n.rdata = s.rxd;
				`H_STAT: n.rdata = {14'h0000, s.phase != H_IDLE, s.done};
				`H_MASK: n.rdata = {15'h0000, s.mask};
				default: n.rdata = 16'h0000;
			endcase
		end
		n.irq = n.done & n.mask;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			s <= '{cs: 1'b1, din_oe_n: 1'b1, din_s: 3'b111, dout_s: 3'b111, din_l: 1'b1, dout_l: 1'b1,
				phase: H_IDLE, default: '0};
		else
			s <= n;
	end

	assign sw_rdata           = s.rdata;
	assign irq                = s.irq;
	assign link.mode_pin      = s.ctrl[`HC_CONTROL_MODE_SELECT_PIN];
	assign link.chan_pin      = s.ctrl[`HC_CHAN];
	assign link.sclk          = s.sclk;
	assign link.sel_pin       = s.cs;
	assign link.host_din_o    = s.din_o;
	assign link.host_din_oe_n = s.din_oe_n;
endmodule : scp_host
`default_nettype wire

// >>> hdl/scp_link_if.sv
// pins between the serial host and the control port device, with line resolution
`timescale 1ns/1ps
`default_nettype none
interface scp_link_if;
	logic mode_pin;
	logic chan_pin;
	logic sclk;
	logic sel_pin;
	logic host_din_o;
	logic host_din_oe_n;
	logic dev_din_o;
	logic dev_din_oe_n;
	logic dev_dout_o;
	logic dev_dout_oe_n;
	logic din_line;
	logic dout_line;

	// both lines are pulled up; drivers that are enabled pull them together
	assign din_line  = (host_din_oe_n | host_din_o) & (dev_din_oe_n | dev_din_o);
	assign dout_line = dev_dout_oe_n | dev_dout_o;

	modport device (
		input  mode_pin, chan_pin, sclk, sel_pin, din_line,
		output dev_din_o, dev_din_oe_n, dev_dout_o, dev_dout_oe_n
	);
	modport host (
		output mode_pin, chan_pin, sclk, sel_pin, host_din_o, host_din_oe_n,
		input  din_line, dout_line
	);
endinterface : scp_link_if
`default_nettype wire

// >>> hdl/scp_pkg.sv
// types shared by both ends of the serial control port link
`include "scp_cfg.svh"
package scp_pkg;

	typedef struct packed {
		logic [2:0]                     sclk_s;
		logic [2:0]                     cs_s;
		logic [2:0]                     din_s;
		logic [2:0]                     mode_s;
		logic [2:0]                     chan_s;
		logic                           sclk_l;
		logic                           cs_l;
		logic                           din_l;
		logic                           mode_l;
		logic                           chan_l;
		logic [23:0]                    shift;
		logic [3:0]                     hcnt;
		logic [4:0]                     dcnt;
		logic [4:0]                     ocnt;
		logic                           blk;
		logic                           rw;
		logic                           tx_on;
		logic                           dout;
		logic [6:0]                     addr;
		logic [15:0]                    tx;
		logic [15:0]                    cfg;
		logic [1:0]                     stat;
		logic [1:0]                     mask;
		logic                           din_oe_n;
		logic                           dout_o;
		logic                           dout_oe_n;
		logic                           irq;
		logic                           alert;
		logic                           right;
		logic                           enable;
		logic                           quad;
		logic [`REG_WORDS-1:0][15:0]    regs;
	} dev_state_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_LOW  = 2'b01,
		H_HIGH = 2'b10,
		H_END  = 2'b11
	} host_phase_t;

	typedef struct packed {
		host_phase_t  phase;
		logic [7:0]   div;
		logic [4:0]   cnt;
		logic [23:0]  shift;
		logic [15:0]  rx;
		logic         rd;
		logic [4:0]   ctrl;
		logic [15:0]  txd;
		logic [15:0]  rxd;
		logic         done;
		logic         mask;
		logic [15:0]  rdata;
		logic         irq;
		logic         sclk;
		logic         cs;
		logic         din_o;
		logic         din_oe_n;
		logic [2:0]   din_s;
		logic [2:0]   dout_s;
		logic         din_l;
		logic         dout_l;
	} host_state_t;

endpackage : scp_pkg
